// file: hw/mii_port_pkg.sv
// shared constants for the port 6 nibble link: straps, pin indices, timing
// assumes a 200 MHz system clock on both ends
//
// What this block does
// R1 - straps choose MII, RMII or RGMII port type; only MII runs here, any other value leaves the port off
// R2 - pins named as a PHY would name them
// R3 - MAC wired straight, PHY wired crosswise
// R4 - four bits per clock, 2.5 or 25 MHz
// R5 - nibbles carry valid and error flags
// R6 - half duplex collision signalled toward MAC side
// R7 - PHY mode facing MAC, MAC mode facing PHY
// R8 - mode flips only clocks, collision, carrier
// R9 - receive pins 3 and 2 strap MII type
// R10 - board straps pin 0 to 100/10 setting
// R11 - receive pin 1 strap picks PHY or MAC
// R12 - PHY mode pin directions as listed
// R13 - MAC mode pin directions as listed
// R14 - transmit and receive groups stay independent
// R15 - each group launched on its own clock; both ends run both groups on one link clock, driven on both clock pins
// R16 - straps latched at reset, held until next
package mii_port_pkg;
  localparam int          CLK_NS            = 5;
  localparam int          MII_100_PERIOD_NS = 40;
  localparam int          MII_10_PERIOD_NS  = 400;
  localparam logic [5:0]  DIV_HALF_100      = 6'(MII_100_PERIOD_NS / CLK_NS / 2);
  localparam logic [5:0]  DIV_HALF_10       = 6'(MII_10_PERIOD_NS / CLK_NS / 2);
  localparam int          NIB_W             = 4;
  localparam int          FIFO_DEPTH        = 16;
  localparam int          EG_W              = 5;
  localparam int          IN_W              = 6;
  localparam int          W_ERR             = 4;
  localparam int          W_START           = 5;
  localparam int          STRAP_HI          = 3;
  localparam int          STRAP_LO          = 2;
  localparam int          STRAP_PM          = 1;
  localparam int          STRAP_SPD         = 0;
  localparam logic [1:0]  STRAP_IFACE_MII   = 2'h1;
  localparam logic        STRAP_PHY_MODE    = 1'h1;
  localparam logic        STRAP_SPEED_10_100 = 1'h0;
  localparam int          BI_TXCLK          = 0;
  localparam int          BI_RXCLK          = 1;
  localparam int          BI_COL            = 2;
  localparam int          BI_CRS            = 3;
endpackage

// file: hw/mii_link_if.sv
// pin-level carrier between the switch port and its partner
// resolves the four two-way pins and the strap pulls on the receive nibble
`timescale 1ns/10ps
`default_nettype none
interface mii_link_if (
  input wire logic [3:0] strap_pull
);
  // fixed-direction pins: transmit group into device, receive group out
  logic       p6_transmit_enable;
  logic       p6_transmit_error;
  logic [3:0] p6_transmit_nibble;
  logic       rx_valid_o;
  logic       rx_error_o;
  logic [3:0] rx_nibble_o;
  logic       rx_oe;
  logic       p6_receive_valid;
  logic       p6_receive_error;
  logic [3:0] p6_receive_nibble;
  // two-way pins: transmit clock, receive clock, collision, carrier sense
  logic [3:0] dev_bi_o;
  logic [3:0] dev_bi_oe;
  logic [3:0] prt_bi_o;
  logic [3:0] prt_bi_oe;
  logic [3:0] bi;

  // undriven receive nibble pins show the board straps; undriven valid and error read low
  assign p6_receive_valid  = rx_oe & rx_valid_o;
  assign p6_receive_error  = rx_oe & rx_error_o;
  assign p6_receive_nibble = rx_oe ? rx_nibble_o : strap_pull;
  assign bi = (dev_bi_oe & dev_bi_o) | (~dev_bi_oe & prt_bi_oe & prt_bi_o);

  modport dev (input p6_transmit_enable, p6_transmit_error, p6_transmit_nibble, p6_receive_nibble, bi,
               output rx_valid_o, rx_error_o, rx_nibble_o, rx_oe, dev_bi_o, dev_bi_oe);
  modport prt (output p6_transmit_enable, p6_transmit_error, p6_transmit_nibble, prt_bi_o, prt_bi_oe,
               input p6_receive_valid, p6_receive_error, p6_receive_nibble, bi);
endinterface
`default_nettype wire

// file: hw/cdc_fifo.sv
// dual-clock FIFO with gray-coded pointers
// assumes each side's reset is synchronous to its own clock
`timescale 1ns/10ps
`default_nettype none
module cdc_fifo #(
  parameter int W     = 5,
  parameter int DEPTH = 16
) (
  input  wire logic         wclk,
  input  wire logic         wrst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  input  wire logic         rclk,
  input  wire logic         rrst_n,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             bin;
    logic [AW:0]             gray;
    logic [AW:0]             rs1;
    logic [AW:0]             rs2;
  } wst_t;
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] ws1;
    logic [AW:0] ws2;
  } rst_t;
  wst_t w_q, w_d;
  rst_t r_q, r_d;
  logic full;
  logic empty;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // full when write pointer is one lap ahead of the synced read pointer
  assign full      = w_q.gray == {~w_q.rs2[AW:AW-1], w_q.rs2[AW-2:0]};
  assign empty     = r_q.gray == r_q.ws2;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = w_q.mem[r_q.bin[AW-1:0]]; // slot is stable while readable

  // write side
  always_comb begin
    w_d     = w_q;
    w_d.rs1 = r_q.gray;
    w_d.rs2 = w_q.rs1;
    if (in_valid && !full) begin
      w_d.mem[w_q.bin[AW-1:0]] = in_data;
      w_d.bin  = w_q.bin + 1'b1;
      w_d.gray = to_gray(w_d.bin);
    end
  end

  always_ff @(posedge wclk) begin
    if (!wrst_n) w_q <= '0;
    else w_q <= w_d;
  end

  // read side
  always_comb begin
    r_d     = r_q;
    r_d.ws1 = w_q.gray;
    r_d.ws2 = r_q.ws1;
    if (out_ready && !empty) begin
      r_d.bin  = r_q.bin + 1'b1;
      r_d.gray = to_gray(r_d.bin);
    end
  end

  always_ff @(posedge rclk) begin
    if (!rrst_n) r_q <= '0;
    else r_q <= r_d;
  end
endmodule // cdc_fifo
`default_nettype wire

// file: hw/mii_port_device.sv
// switch end of the port 6 nibble link: strap capture, mode, both groups
// assumes link_clk is the clock on the transmit clock pin: made by the bench in
// PHY mode, tied to the partner's clock pin in MAC mode
`timescale 1ns/10ps
`default_nettype none
module mii_port_device
  import mii_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             link_clk,
  mii_link_if.dev               link,
  input  wire logic             egress_valid,
  output logic                  egress_ready,
  input  wire logic [NIB_W-1:0] egress_nibble,
  input  wire logic             egress_error,
  output logic                  ingress_valid,
  input  wire logic             ingress_ready,
  output logic [NIB_W-1:0]      ingress_nibble,
  output logic                  ingress_error,
  output logic                  ingress_start,
  input  wire logic             half_duplex,
  output logic                  mii_selected,
  output logic                  phy_mode,
  output logic                  speed_ok,
  output logic                  collision_seen,
  output logic                  carrier_seen,
  output logic                  ingress_overrun
);
  typedef enum logic [2:0] {
    ST_STRAP = 3'b001,
    ST_OFF   = 3'b010,
    ST_RUN   = 3'b100
  } st_t;

  typedef struct packed {
    st_t        st;
    logic [3:0] sp1;
    logic [3:0] sp2;
    logic [3:0] cfg;
    logic       col1;
    logic       col2;
    logic       crs1;
    logic       crs2;
    logic       ov1;
    logic       ov2;
    logic       mii_sel;
    logic       phy;
    logic       spd_ok;
    logic       col_seen;
    logic       crs_seen;
    logic       overrun;
  } sys_t;

  typedef struct packed {
    logic             rst1;
    logic             rst2;
    logic             run1;
    logic             run2;
    logic             phy1;
    logic             phy2;
    logic             hd1;
    logic             hd2;
    logic             tx_en_prev;
    logic             rx_oe;
    logic             rx_valid;
    logic             rx_error;
    logic [NIB_W-1:0] rx_nibble;
    logic             col;
    logic             crs;
    logic             overrun;
  } lnk_t;

  sys_t c_q, c_d;
  lnk_t l_q, l_d;
  logic            run;
  logic            eg_valid;
  logic [EG_W-1:0] eg_data;
  logic            in_push;
  logic            in_ready;
  logic [IN_W-1:0] in_data;
  logic [IN_W-1:0] ig_data;

  assign run = c_q.st == ST_RUN;

  // egress nibbles cross into the link clock and leave on the receive group
  cdc_fifo #(
    .W     (EG_W),
    .DEPTH (DEPTH)
  ) u_egress (
    .wclk      (clk),
    .wrst_n    (rstn),
    .in_valid  (egress_valid & run),
    .in_ready  (egress_ready),
    .in_data   ({egress_error, egress_nibble}),
    .rclk      (link_clk),
    .rrst_n    (l_q.rst2),
    .out_valid (eg_valid),
    .out_ready (l_q.run2),
    .out_data  (eg_data)
  );

  // transmit-group nibbles cross back into the system clock
  cdc_fifo #(
    .W     (IN_W),
    .DEPTH (DEPTH)
  ) u_ingress (
    .wclk      (link_clk),
    .wrst_n    (l_q.rst2),
    .in_valid  (in_push),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .rclk      (clk),
    .rrst_n    (rstn),
    .out_valid (ingress_valid),
    .out_ready (ingress_ready),
    .out_data  (ig_data)
  );

  assign ingress_nibble = ig_data[NIB_W-1:0];
  assign ingress_error  = ig_data[W_ERR];
  assign ingress_start  = ig_data[W_START];

  // system side: strap capture during reset, then mode decision
  always_comb begin
    c_d      = c_q;
    c_d.sp1  = link.p6_receive_nibble;
    c_d.sp2  = c_q.sp1;
    c_d.col1 = link.bi[BI_COL];
    c_d.col2 = c_q.col1;
    c_d.crs1 = link.bi[BI_CRS];
    c_d.crs2 = c_q.crs1;
    c_d.ov1  = l_q.overrun;
    c_d.ov2  = c_q.ov1;
    if (!rstn) begin
      c_d.st       = ST_STRAP;
      c_d.cfg      = c_q.sp2;                                // see R9, see R16
      c_d.mii_sel  = 1'b0;
      c_d.phy      = 1'b0;
      c_d.spd_ok   = 1'b0;
      c_d.col_seen = 1'b0;
      c_d.crs_seen = 1'b0;
      c_d.overrun  = 1'b0;
    end else begin
      case (c_q.st)
        ST_STRAP: begin
          if (c_q.cfg[STRAP_HI:STRAP_LO] == STRAP_IFACE_MII) c_d.st = ST_RUN; // see R1, see R9
          else c_d.st = ST_OFF;
          c_d.mii_sel = c_q.cfg[STRAP_HI:STRAP_LO] == STRAP_IFACE_MII;
          c_d.phy     = c_q.cfg[STRAP_PM] == STRAP_PHY_MODE;          // see R7, see R11
          c_d.spd_ok  = c_q.cfg[STRAP_SPD] == STRAP_SPEED_10_100;     // see R10
        end
        ST_OFF:  c_d.st = ST_OFF;
        ST_RUN:  c_d.st = ST_RUN;
        default: c_d.st = ST_STRAP;
      endcase
      // collision and carrier are pin inputs only in MAC mode
      c_d.col_seen = run & ~c_q.phy & c_q.col2;                       // see R13
      c_d.crs_seen = run & ~c_q.phy & c_q.crs2;                       // see R13
      c_d.overrun  = c_q.ov2;
    end
  end

  always_ff @(posedge clk) begin
    c_q <= c_d;
  end

  // link side: transmit group sampled, receive group launched on link_clk
  assign in_push = l_q.run2 & link.p6_transmit_enable;               // see R5, see R15
  assign in_data = {link.p6_transmit_enable & ~l_q.tx_en_prev, link.p6_transmit_error,
                    link.p6_transmit_nibble};                         // see R4, see R14

  always_comb begin
    l_d            = l_q;
    l_d.rst1       = rstn;
    l_d.rst2       = l_q.rst1;
    l_d.run1       = run;
    l_d.run2       = l_q.run1;
    l_d.phy1       = c_q.phy;
    l_d.phy2       = l_q.phy1;
    l_d.hd1        = half_duplex;
    l_d.hd2        = l_q.hd1;
    l_d.tx_en_prev = link.p6_transmit_enable;
    // receive pins stay released while straps are read
    l_d.rx_oe      = l_q.run2;                                        // see R2, see R12
    l_d.rx_valid   = l_q.run2 & eg_valid;                             // see R5, see R15
    l_d.rx_error   = l_q.run2 & eg_valid & eg_data[W_ERR];
    l_d.rx_nibble  = eg_valid ? eg_data[NIB_W-1:0] : '0;              // see R4
    // toward an attached MAC: in half duplex, collision when both groups carry a frame
    l_d.col        = l_q.phy2 & l_q.hd2 & link.p6_transmit_enable & l_q.rx_valid; // see R6
    l_d.crs        = l_q.phy2 & (link.p6_transmit_enable | l_q.rx_valid);
    l_d.overrun    = l_q.overrun | (in_push & ~in_ready);             // sticky until reset
    if (!l_q.rst2) begin
      l_d      = '0;
      l_d.rst1 = rstn;
      l_d.rst2 = l_q.rst1;
    end
  end

  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  // pin drivers; clocks are forwarded, so only PHY mode drives them
  assign link.rx_valid_o  = l_q.rx_valid;
  assign link.rx_error_o  = l_q.rx_error;
  assign link.rx_nibble_o = l_q.rx_nibble;
  assign link.rx_oe       = l_q.rx_oe;
  assign link.dev_bi_o    = {l_q.crs, l_q.col, link_clk, link_clk};   // see R12
  assign link.dev_bi_oe   = {4{l_q.phy2 & l_q.run2}};                 // see R8, see R13

  // status toward the user side
  assign mii_selected    = c_q.mii_sel;
  assign phy_mode        = c_q.phy;
  assign speed_ok        = c_q.spd_ok;
  assign collision_seen  = c_q.col_seen;
  assign carrier_seen    = c_q.crs_seen;
  assign ingress_overrun = c_q.overrun;
endmodule // mii_port_device
`default_nettype wire

// file: hw/mii_port_partner.sv
// far end of the port 6 link: an external MAC, or an external PHY that makes the clock
// assumes the role input is held steady across reset
`timescale 1ns/10ps
`default_nettype none
module mii_port_partner
  import mii_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             is_phy,
  input  wire logic             speed_10,
  input  wire logic             half_duplex,
  mii_link_if.prt               link,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  input  wire logic [NIB_W-1:0] tx_nibble,
  input  wire logic             tx_error,
  output logic                  rx_valid,
  input  wire logic             rx_ready,
  output logic [NIB_W-1:0]      rx_nibble,
  output logic                  rx_error,
  output logic                  rx_start,
  output logic                  collision_seen,
  output logic                  carrier_seen
);
  typedef struct packed {
    logic       role;
    logic       slow;
    logic [6:0] cnt;
    logic       div;
    logic       col1;
    logic       col2;
    logic       crs1;
    logic       crs2;
  } sys_t;
  typedef struct packed {
    logic             rst1;
    logic             rst2;
    logic             ph1;
    logic             ph2;
    logic             hd1;
    logic             hd2;
    logic             rxv_prev;
    logic             tx_en;
    logic             tx_err;
    logic [NIB_W-1:0] tx_nib;
    logic             col;
    logic             crs;
  } lnk_t;
  sys_t c_q, c_d;
  lnk_t l_q, l_d;
  logic            link_w;
  logic            tq_valid;
  logic [EG_W-1:0] tq_data;
  logic [IN_W-1:0] rq_data;
  logic [5:0]      half;

  // as a PHY this end makes the link clock, as a MAC it takes it from the pin
  assign link_w = c_q.role ? c_q.div : link.bi[BI_TXCLK];
  assign half   = c_q.slow ? DIV_HALF_10 : DIV_HALF_100;              // see R4

  cdc_fifo #(.W(EG_W), .DEPTH(DEPTH)) u_tx (
    .wclk(clk), .wrst_n(rstn), .in_valid(tx_valid), .in_ready(tx_ready),
    .in_data({tx_error, tx_nibble}), .rclk(link_w), .rrst_n(l_q.rst2),
    .out_valid(tq_valid), .out_ready(l_q.rst2), .out_data(tq_data));

  cdc_fifo #(.W(IN_W), .DEPTH(DEPTH)) u_rx (
    .wclk(link_w), .wrst_n(l_q.rst2), .in_valid(link.p6_receive_valid),
    .in_ready(), .in_data({link.p6_receive_valid & ~l_q.rxv_prev, link.p6_receive_error,
                           link.p6_receive_nibble}),
    .rclk(clk), .rrst_n(rstn), .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rq_data));

  assign rx_nibble = rq_data[NIB_W-1:0];
  assign rx_error  = rq_data[W_ERR];
  assign rx_start  = rq_data[W_START];

  // system side: role capture and clock divider
  always_comb begin
    c_d      = c_q;
    c_d.col1 = link.bi[BI_COL];
    c_d.col2 = c_q.col1;
    c_d.crs1 = link.bi[BI_CRS];
    c_d.crs2 = c_q.crs1;
    if (!rstn) begin
      c_d.role = is_phy;
      c_d.slow = speed_10;
    end
    // divider runs through reset, so both link sides see their reset edges
    if (c_q.cnt < {half, 1'b0} - 7'h01) begin
      c_d.cnt = c_q.cnt + 7'h01;
    end else begin
      c_d.cnt = '0;
    end
    c_d.div = c_d.cnt >= {1'b0, half};                                  // see R4
  end

  always_ff @(posedge clk) begin
    c_q <= c_d;
  end

  // link side: transmit pins launched, collision made when acting as PHY
  always_comb begin
    l_d          = l_q;
    l_d.rst1     = rstn;
    l_d.rst2     = l_q.rst1;
    l_d.ph1      = c_q.role;
    l_d.ph2      = l_q.ph1;
    l_d.hd1      = half_duplex;
    l_d.hd2      = l_q.hd1;
    l_d.rxv_prev = link.p6_receive_valid;
    l_d.tx_en    = tq_valid;                                          // see R5, see R15
    l_d.tx_err   = tq_valid & tq_data[W_ERR];
    l_d.tx_nib   = tq_valid ? tq_data[NIB_W-1:0] : '0;
    l_d.col      = l_q.ph2 & l_q.hd2 & l_q.tx_en & link.p6_receive_valid; // see R6
    l_d.crs      = l_q.ph2 & (l_q.tx_en | link.p6_receive_valid);
    if (!l_q.rst2) begin
      l_d      = '0;
      l_d.rst1 = rstn;
      l_d.rst2 = l_q.rst1;
    end
  end

  always_ff @(posedge link_w) begin
    l_q <= l_d;
  end

  // fixed transmit pins; clocks, collision and carrier only as PHY
  assign link.p6_transmit_enable = l_q.tx_en;                         // see R3
  assign link.p6_transmit_error  = l_q.tx_err;
  assign link.p6_transmit_nibble = l_q.tx_nib;
  assign link.prt_bi_o           = {l_q.crs, l_q.col, c_q.div, c_q.div};
  assign link.prt_bi_oe          = {{2{c_q.role & l_q.rst2}}, {2{c_q.role}}};
  assign collision_seen          = ~c_q.role & c_q.col2;
  assign carrier_seen            = ~c_q.role & c_q.crs2;
endmodule // mii_port_partner
`default_nettype wire

// file: test/port6_mii_interface_checker.sv
// assertions on the port 6 nibble link, watching the carrier's pins
// assumes bi[0] carries the link clock and rstn is the switch end's reset
`timescale 1ns/10ps
`default_nettype none
module port6_mii_interface_checker
  import mii_port_pkg::*;
(
  input wire logic       rstn,
  input wire logic [3:0] strap_pull,
  input wire logic [3:0] bi,
  input wire logic [3:0] dev_bi_o,
  input wire logic [3:0] dev_bi_oe,
  input wire logic [3:0] prt_bi_oe,
  input wire logic       rx_oe,
  input wire logic       rx_valid_o,
  input wire logic       p6_receive_valid,
  input wire logic       p6_receive_error,
  input wire logic       p6_transmit_enable
);
  default clocking cb @(posedge bi[BI_TXCLK]); endclocking
  default disable iff (!rstn);

  // either group busy on the pins
  logic any_valid;
  assign any_valid = p6_receive_valid | p6_transmit_enable;

  // port drive and pin directions
  property p_rx_needs_oe; rx_valid_o |-> rx_oe; endproperty
  a_rx_needs_oe: assert property (p_rx_needs_oe) else $error("receive valid without drive");
  property p_oe_held; rx_oe |=> rx_oe; endproperty
  a_oe_held: assert property (p_oe_held) else $error("receive drive dropped in run");
  property p_iface_strap; rx_oe |-> strap_pull[STRAP_HI:STRAP_LO] == STRAP_IFACE_MII; endproperty
  a_iface_strap: assert property (p_iface_strap) else $error("port driven without nibble strap");
  property p_dev_dir; rx_oe [*3] |-> dev_bi_oe == {4{strap_pull[STRAP_PM]}}; endproperty
  a_dev_dir: assert property (p_dev_dir) else $error("switch end two-way pins wrong");
  property p_prt_dir; rx_oe [*3] |-> prt_bi_oe == {4{~strap_pull[STRAP_PM]}}; endproperty
  a_prt_dir: assert property (p_prt_dir) else $error("far end two-way pins wrong");

  // collision, carrier and receive error from the switch end
  property p_col_crs; dev_bi_oe[BI_COL] && dev_bi_o[BI_COL] |-> dev_bi_o[BI_CRS]; endproperty
  a_col_crs: assert property (p_col_crs) else $error("collision without carrier");
  property p_crs_follows;
    dev_bi_oe[BI_CRS] ##1 dev_bi_oe[BI_CRS] |-> dev_bi_o[BI_CRS] == $past(any_valid);
  endproperty
  a_crs_follows: assert property (p_crs_follows) else $error("carrier not one clock after valid");
  property p_err_in_frame; p6_receive_error |-> p6_receive_valid; endproperty
  a_err_in_frame: assert property (p_err_in_frame) else $error("receive error outside frame");

  // main scenarios
  c_frame: cover property ($rose(p6_receive_valid));
  c_col: cover property (dev_bi_oe[BI_COL] && dev_bi_o[BI_COL]);
  c_mac: cover property (rx_oe && !dev_bi_oe[BI_TXCLK]);
endmodule // port6_mii_interface_checker
`default_nettype wire

// file: test/port6_mii_interface_tb.sv
// self-checking bench: switch end and far end joined over the nibble link
// assumes a 200 MHz clk; bench link clock of 125 ns feeds PHY mode only
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module port6_mii_interface_tb
  import mii_port_pkg::*;
;
  logic       clk = 0, lclk = 0, rstn = 0, prstn = 0, hd = 0, is_phy = 0, slow = 0;
  logic       ev = 0, ee = 0, ir = 1, tv = 0, te = 0, rr = 1;
  logic [3:0] strap = 4'h6, en = 4'h0, tn = 4'h0, in_n, rn;
  logic       er, iv, ie, is_s, mii, pm, sok, dcol, dcrs, ovr;
  logic       tr, rv, re, rs, pcol, pcrs, dev_lclk, col_hit, crs_hit;
  logic [5:0] pq[$], dq[$];
  int         err_count = 0, cmp_count = 0, cyc = 0;

  // system clock and free-running link clock
  initial begin forever #2.5 clk = ~clk; end
  initial begin #17.3; forever #62.5 lclk = ~lclk; end

  mii_link_if i_mii_link_if (.strap_pull(strap));
  // MAC mode: switch end runs on the clock the far end drives
  assign dev_lclk = strap[STRAP_PM] ? lclk : i_mii_link_if.bi[BI_TXCLK];

  mii_port_device i_mii_port_device (
    .clk(clk), .rstn(rstn), .link_clk(dev_lclk), .link(i_mii_link_if.dev),
    .egress_valid(ev), .egress_ready(er), .egress_nibble(en), .egress_error(ee),
    .ingress_valid(iv), .ingress_ready(ir), .ingress_nibble(in_n), .ingress_error(ie),
    .ingress_start(is_s), .half_duplex(hd), .mii_selected(mii), .phy_mode(pm), .speed_ok(sok),
    .collision_seen(dcol), .carrier_seen(dcrs), .ingress_overrun(ovr));
  mii_port_partner i_mii_port_partner (
    .clk(clk), .rstn(prstn), .is_phy(is_phy), .speed_10(slow), .half_duplex(hd),
    .link(i_mii_link_if.prt), .tx_valid(tv), .tx_ready(tr), .tx_nibble(tn), .tx_error(te),
    .rx_valid(rv), .rx_ready(rr), .rx_nibble(rn), .rx_error(re), .rx_start(rs),
    .collision_seen(pcol), .carrier_seen(pcrs));
  port6_mii_interface_checker u_checker (
    .rstn(rstn), .strap_pull(strap), .bi(i_mii_link_if.bi), .dev_bi_o(i_mii_link_if.dev_bi_o),
    .dev_bi_oe(i_mii_link_if.dev_bi_oe), .prt_bi_oe(i_mii_link_if.prt_bi_oe),
    .rx_oe(i_mii_link_if.rx_oe), .rx_valid_o(i_mii_link_if.rx_valid_o),
    .p6_receive_valid(i_mii_link_if.p6_receive_valid),
    .p6_receive_error(i_mii_link_if.p6_receive_error),
    .p6_transmit_enable(i_mii_link_if.p6_transmit_enable));

  // collect words taken by both user sides, flag collision and carrier
  always @(negedge clk) begin
    if (rv && rr) pq.push_back({rs, re, rn});
    if (iv && ir) dq.push_back({is_s, ie, in_n});
    if (dcol || pcol) col_hit = 1;
    if (dcrs || pcrs) crs_hit = 1;
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // reset under the old straps until the pins are released, then swap straps and roles
  // so no clock pin loops back on itself; clock maker released first
  task automatic start(input logic [3:0] s, input logic h);
    rstn <= 0; prstn <= 0;
    repeat (120) @(posedge clk);
    strap <= s; hd <= h; is_phy <= ~s[STRAP_PM];
    repeat (120) @(posedge clk);
    if (s[STRAP_PM]) rstn <= 1; else prstn <= 1;
    repeat (300) @(posedge clk);
    rstn <= 1; prstn <= 1;
    repeat (400) @(posedge clk);
    col_hit = 0; crs_hit = 0; pq.delete(); dq.delete();
  endtask

  // one word into the switch end (far = 0) or the far end (far = 1)
  task automatic put(input logic far, input logic [3:0] n, input logic e);
    logic r;
    if (far) begin tv <= 1; tn <= n; te <= e; end
    else begin ev <= 1; en <= n; ee <= e; end
    do begin @(negedge clk); r = far ? tr : er; @(posedge clk); end while (!r);
  endtask

  task automatic wait_q(input int np, input int nd);
    for (int k = 0; k < 3000 && (pq.size() < np || dq.size() < nd); k++) @(posedge clk);
  endtask

  // frames both ways at once, strap status, collision only in half duplex
  task automatic t_stream(input logic [3:0] s, input logic h);
    realtime t0;
    start(s, h);
    `CHK(mii, 1'b1)
    `CHK(pm, s[STRAP_PM])
    `CHK(sok, 1'b1)
    // link clock period on the transmit clock pin
    @(posedge i_mii_link_if.bi[BI_TXCLK]) t0 = $realtime;
    @(posedge i_mii_link_if.bi[BI_TXCLK]);
    `CHK(int'($realtime - t0), s[STRAP_PM] ? 125 : (slow ? MII_10_PERIOD_NS : MII_100_PERIOD_NS))
    @(posedge clk);
    fork
      begin for (int i = 0; i < 8; i++) put(0, 4'(i + 3), i == 5); ev <= 0; end
      begin for (int i = 0; i < 8; i++) put(1, 4'(12 - i), i == 2); tv <= 0; end
    join
    wait_q(8, 8);
    for (int i = 0; i < 8; i++) begin
      `CHK(pq[i], {i == 0, i == 5, 4'(i + 3)})
      `CHK(dq[i], {i == 0, i == 2, 4'(12 - i)})
    end
    `CHK(col_hit, h)
    `CHK(crs_hit, 1'b1)
  endtask

  // other interface strap: port stays released and ignores the transmit pins
  task automatic t_off;
    start(4'h9, 1'b0);
    `CHK(mii, 1'b0)
    `CHK(i_mii_link_if.p6_receive_nibble, 4'h9)
    for (int i = 0; i < 4; i++) put(1, 4'(i), 1'b0);
    tv <= 0;
    repeat (200) @(posedge clk);
    `CHK(dq.size(), 0)
  endtask

  // stalled ingress fills to 16, later nibbles lost and flagged, reset clears
  task automatic t_overrun;
    start(4'h6, 1'b0);
    ir <= 0;
    for (int i = 0; i < 20; i++) put(1, 4'(i), 1'b0);
    tv <= 0;
    repeat (600) @(posedge clk);
    `CHK(ovr, 1'b1)
    ir <= 1;
    wait_q(0, 16);
    repeat (20) @(posedge clk);
    `CHK(dq.size(), 16)
    for (int i = 0; i < 16; i++) `CHK(dq[i], {i == 0, 1'b0, 4'(i)})
    start(4'h6, 1'b0);
    `CHK(ovr, 1'b0)
  endtask

  initial begin
    t_stream(4'h6, 1'b0);
    t_stream(4'h4, 1'b0);
    t_stream(4'h6, 1'b1);
    t_stream(4'h4, 1'b1);
    slow <= 1;
    t_stream(4'h4, 1'b1);
    t_off();
    t_overrun();
    tally_and_finish();
  end
endmodule // port6_mii_interface_tb
`default_nettype wire
